// [sdc_pkg.sv]
package sdc_pkg;

  // byte addresses of the three registers on the system bus
  localparam logic [31:0] SDC_COMMAND_ADDR  = 32'hF002_0004;
  localparam logic [31:0] SDC_REFRESH_ADDR  = 32'hF002_0008;
  localparam logic [31:0] SDC_TIMEOUT_ADDR  = 32'hF002_000C;

  // command register fields
  localparam int          SDC_INIT_LSB      = 0;
  localparam int          SDC_INIT_MSB      = 1;
  localparam int          SDC_MERGE_BIT     = 2;
  localparam int          SDC_BUSY_BIT      = 3;

  // initialization field encodings
  localparam logic [1:0]  SDC_INIT_NORMAL   = 2'h0;
  localparam logic [1:0]  SDC_INIT_PRE_ALL  = 2'h1;
  localparam logic [1:0]  SDC_INIT_MODE_SET = 2'h2;
  localparam logic [1:0]  SDC_INIT_RESERVED = 2'h3;

  // widths and reset values
  localparam int          SDC_COUNT_W       = 16;
  localparam logic [15:0] SDC_REFRESH_RESET = 16'h0020;
  localparam logic [15:0] SDC_TIMEOUT_RESET = 16'h0000;
  localparam logic [1:0]  SDC_INIT_RESET    = 2'h0;
  localparam logic        SDC_MERGE_RESET   = 1'b0;

  // bus responses
  localparam logic [1:0]  SDC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  SDC_RESP_SLVERR   = 2'h2;

  // requests to the sdram engine, and its acknowledges in the same layout
  typedef struct packed {
    logic precharge_all_banks;
    logic mode_set;
    logic refresh;
    logic flush;
  } sdc_engine_req_t;

endpackage

// [sdc_refresh_timer.sv]
`timescale 1ns/100ps
module sdc_refresh_timer
  import sdc_pkg::*;
#(
  parameter int CNT_W = SDC_COUNT_W
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [CNT_W-1:0] refresh_spacing,
  output logic                  expire
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             expire_reg;
  logic             expire_next;
  logic [CNT_W-1:0] reload;

  // a new spacing is picked up at the next reload, not mid-interval
  always_comb begin
    reload      = (refresh_spacing == '0) ? '0 : refresh_spacing - 1'b1;
    count_next  = count_reg - 1'b1;
    expire_next = 1'b0;
    if (count_reg == '0) begin
      count_next  = reload;
      expire_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg  <= CNT_W'(SDC_REFRESH_RESET - 16'h0001);
      expire_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;

  property p_refresh_reload;
    @(posedge clock) disable iff (reset)
    (count_reg == '0) |=> (expire_reg &&
      count_reg == (($past(refresh_spacing) == '0) ? '0 :
                    $past(refresh_spacing) - 1'b1));
  endproperty
  a_refresh_reload: assert property (p_refresh_reload)
    else $error("refresh counter did not reload or expire");

endmodule

// [sdc_flush_timer.sv]
`timescale 1ns/100ps
module sdc_flush_timer
  import sdc_pkg::*;
#(
  parameter int CNT_W = SDC_COUNT_W
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] flush_delay,
  output logic                  expire
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             armed_reg;
  logic             armed_next;
  logic             expire_reg;
  logic             expire_next;

  always_comb begin
    count_next  = count_reg;
    armed_next  = armed_reg;
    expire_next = 1'b0;
    if (load) begin
      count_next = flush_delay;
      armed_next = (flush_delay != '0);
    end else if (armed_reg) begin
      if (count_reg == '0) begin
        armed_next  = 1'b0;
        expire_next = 1'b1;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg  <= '0;
      armed_reg  <= 1'b0;
      expire_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      armed_reg  <= armed_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;

  property p_flush_load;
    @(posedge clock) disable iff (reset)
    load |=> (count_reg == $past(flush_delay)) &&
             (armed_reg == ($past(flush_delay) != '0));
  endproperty
  a_flush_load: assert property (p_flush_load)
    else $error("flush counter not loaded from delay field");

  property p_flush_zero_off;
    @(posedge clock) disable iff (reset)
    (load && flush_delay == '0) ##1 !load [*2] |-> !expire_reg;
  endproperty
  a_flush_zero_off: assert property (p_flush_zero_off)
    else $error("flush fired with zero delay");

  property p_flush_step;
    @(posedge clock) disable iff (reset)
    (armed_reg && !load && count_reg != '0) |=>
      (count_reg == $past(count_reg) - 1'b1) && !expire_reg;
  endproperty
  a_flush_step: assert property (p_flush_step)
    else $error("flush counter did not step down by one");

  property p_flush_fire;
    @(posedge clock) disable iff (reset)
    (armed_reg && !load && count_reg == '0) |=> expire_reg && !armed_reg;
  endproperty
  a_flush_fire: assert property (p_flush_fire)
    else $error("flush did not fire at zero");

endmodule

// [sdc_cmd_refresh_merge_buffer_enable.sv]
`timescale 1ns/100ps
module sdc_cmd_refresh_merge_buffer_enable
  import sdc_pkg::*;
#(
  parameter bit HAS_WRITE_BUFFER = 1'b1,
  parameter int CNT_W            = SDC_COUNT_W
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic [31:0]     s_axi_awaddr,
  input  wire logic [2:0]      s_axi_awprot,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [31:0]     s_axi_araddr,
  input  wire logic [2:0]      s_axi_arprot,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output sdc_engine_req_t      engine_req,
  input  wire sdc_engine_req_t engine_ack,
  input  wire logic            engine_busy,
  input  wire logic            buffer_write,
  output logic                 merge_buffer_enable
);

  // write channel state
  logic             aw_held_reg;
  logic             aw_held_next;
  logic [31:0]      aw_addr_reg;
  logic [31:0]      aw_addr_next;
  logic             w_held_reg;
  logic             w_held_next;
  logic [31:0]      w_data_reg;
  logic [31:0]      w_data_next;
  logic [3:0]       w_strb_reg;
  logic [3:0]       w_strb_next;
  logic             awready_reg;
  logic             awready_next;
  logic             wready_reg;
  logic             wready_next;
  logic             bvalid_reg;
  logic             bvalid_next;
  logic [1:0]       bresp_reg;
  logic [1:0]       bresp_next;

  // read channel state
  logic             arready_reg;
  logic             arready_next;
  logic             rvalid_reg;
  logic             rvalid_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [1:0]       rresp_reg;
  logic [1:0]       rresp_next;

  // software registers and engine requests
  logic [1:0]       init_reg;
  logic [1:0]       init_next;
  logic             merge_reg;
  logic             merge_next;
  logic [CNT_W-1:0] refresh_reg;
  logic [CNT_W-1:0] refresh_next;
  logic [CNT_W-1:0] timeout_reg;
  logic [CNT_W-1:0] timeout_next;
  sdc_engine_req_t  req_reg;
  sdc_engine_req_t  req_next;

  logic             aw_take;
  logic             w_take;
  logic             ar_take;
  logic             do_write;
  logic             wr_command;
  logic             wr_refresh;
  logic             wr_timeout;
  logic             merge_off_event;
  logic             busy;
  logic             refresh_expire;
  logic             flush_expire;
  logic             buffer_load;

  function automatic logic [CNT_W-1:0] lane_merge(
    input logic [CNT_W-1:0] old_value,
    input logic [31:0]      data,
    input logic [3:0]       strb
  );
    logic [CNT_W-1:0] result;
    result = old_value;
    for (int b = 0; b < CNT_W / 8; b++) begin
      if (strb[b]) begin
        result[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return result;
  endfunction

  assign aw_take  = s_axi_awvalid && awready_reg;
  assign w_take   = s_axi_wvalid && wready_reg;
  assign ar_take  = s_axi_arvalid && arready_reg;
  // write commits the cycle after both halves are held
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  assign wr_command = do_write && (aw_addr_reg == SDC_COMMAND_ADDR);
  assign wr_refresh = do_write && (aw_addr_reg == SDC_REFRESH_ADDR);
  assign wr_timeout = do_write && (aw_addr_reg == SDC_TIMEOUT_ADDR);

  // pending requests count as busy so software sees its own commands
  assign busy = engine_busy || (req_reg != '0);

  // only writes while merging is on reach the buffer
  assign buffer_load = buffer_write && merge_reg;

  // write channel
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wr_command || wr_refresh || wr_timeout) ?
                     SDC_RESP_OKAY : SDC_RESP_SLVERR;
    end
    awready_next = !aw_held_next;
    wready_next  = !w_held_next;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SDC_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // read channel; data is captured at the address handshake
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next  = SDC_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      unique case (s_axi_araddr)
        SDC_COMMAND_ADDR: begin
          rdata_next[SDC_INIT_MSB:SDC_INIT_LSB] = init_reg;
          rdata_next[SDC_MERGE_BIT]              = merge_reg;
          rdata_next[SDC_BUSY_BIT]               = busy;
        end
        SDC_REFRESH_ADDR: rdata_next[CNT_W-1:0] = refresh_reg;
        SDC_TIMEOUT_ADDR: rdata_next[CNT_W-1:0] = timeout_reg;
        default:          rresp_next = SDC_RESP_SLVERR;
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= SDC_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // software registers and requests to the engine
  always_comb begin
    init_next       = init_reg;
    merge_next      = merge_reg;
    refresh_next    = refresh_reg;
    timeout_next    = timeout_reg;
    merge_off_event = 1'b0;
    // a new init command is refused while one is still outstanding
    if (wr_command && w_strb_reg[0]) begin
      if (init_reg == SDC_INIT_NORMAL &&
          w_data_reg[SDC_INIT_MSB:SDC_INIT_LSB] != SDC_INIT_RESERVED) begin
        init_next = w_data_reg[SDC_INIT_MSB:SDC_INIT_LSB];
      end
      if (HAS_WRITE_BUFFER) begin
        merge_next      = w_data_reg[SDC_MERGE_BIT];
        merge_off_event = merge_reg && !w_data_reg[SDC_MERGE_BIT];
      end
    end
    if (wr_refresh) begin
      refresh_next = lane_merge(refresh_reg, w_data_reg, w_strb_reg);
    end
    if (wr_timeout) begin
      timeout_next = lane_merge(timeout_reg, w_data_reg, w_strb_reg);
    end
    // the init field returns to normal once the engine takes the command
    if ((req_reg.precharge_all_banks && engine_ack.precharge_all_banks) ||
        (req_reg.mode_set && engine_ack.mode_set)) begin
      init_next = SDC_INIT_NORMAL;
    end
    req_next.precharge_all_banks = (init_next == SDC_INIT_PRE_ALL);
    req_next.mode_set            = (init_next == SDC_INIT_MODE_SET);
    // a new event in the acknowledge cycle keeps the request up
    req_next.refresh = (req_reg.refresh && !engine_ack.refresh) ||
                       refresh_expire;
    req_next.flush   = (req_reg.flush && !engine_ack.flush) ||
                       merge_off_event || flush_expire;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      init_reg    <= SDC_INIT_RESET;
      merge_reg   <= SDC_MERGE_RESET;
      refresh_reg <= CNT_W'(SDC_REFRESH_RESET);
      timeout_reg <= CNT_W'(SDC_TIMEOUT_RESET);
      req_reg     <= '0;
    end else begin
      init_reg    <= init_next;
      merge_reg   <= merge_next;
      refresh_reg <= refresh_next;
      timeout_reg <= timeout_next;
      req_reg     <= req_next;
    end
  end

  sdc_refresh_timer #(
    .CNT_W           (CNT_W)
  ) u_refresh_timer (
    .clock           (clock),
    .reset           (reset),
    .refresh_spacing (refresh_reg),
    .expire          (refresh_expire)
  );

  sdc_flush_timer #(
    .CNT_W       (CNT_W)
  ) u_flush_timer (
    .clock       (clock),
    .reset       (reset),
    .load        (buffer_load),
    .flush_delay (timeout_reg),
    .expire      (flush_expire)
  );

  assign s_axi_awready       = awready_reg;
  assign s_axi_wready        = wready_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = arready_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign engine_req          = req_reg;
  assign merge_buffer_enable = merge_reg;

  property p_init_issue;
    @(posedge clock) disable iff (reset)
    (wr_command && w_strb_reg[0] && init_reg == SDC_INIT_NORMAL &&
     w_data_reg[SDC_INIT_MSB:SDC_INIT_LSB] == SDC_INIT_PRE_ALL) |=>
      engine_req.precharge_all_banks && !engine_req.mode_set;
  endproperty
  a_init_issue: assert property (p_init_issue)
    else $error("precharge-all not requested after init write");

  property p_init_reserved;
    @(posedge clock) disable iff (reset)
    (init_reg == SDC_INIT_NORMAL) ##1 (init_reg == SDC_INIT_RESERVED)
      |-> 1'b0;
  endproperty
  a_init_reserved: assert property (p_init_reserved)
    else $error("reserved init code was accepted");

  property p_merge_write;
    @(posedge clock) disable iff (reset)
    (wr_command && w_strb_reg[0] && HAS_WRITE_BUFFER) |=>
      merge_buffer_enable == $past(w_data_reg[SDC_MERGE_BIT]);
  endproperty
  a_merge_write: assert property (p_merge_write)
    else $error("merge enable did not follow the write");

  property p_merge_off_flush;
    @(posedge clock) disable iff (reset)
    (wr_command && w_strb_reg[0] && HAS_WRITE_BUFFER && merge_reg &&
     !w_data_reg[SDC_MERGE_BIT]) |=> engine_req.flush;
  endproperty
  a_merge_off_flush: assert property (p_merge_off_flush)
    else $error("disabling merge did not request a flush");

  property p_busy_read;
    @(posedge clock) disable iff (reset)
    (ar_take && s_axi_araddr == SDC_COMMAND_ADDR) |=>
      s_axi_rdata[SDC_BUSY_BIT] == $past(busy);
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("busy bit does not reflect controller state");

  property p_no_buffer;
    @(posedge clock) disable iff (reset)
    !HAS_WRITE_BUFFER |-> !merge_buffer_enable;
  endproperty
  a_no_buffer: assert property (p_no_buffer)
    else $error("merge enable set without write buffers");

  property p_refresh_reset;
    @(posedge clock)
    reset |=> refresh_reg == CNT_W'(SDC_REFRESH_RESET);
  endproperty
  a_refresh_reset: assert property (p_refresh_reset)
    else $error("refresh spacing not 32 after reset");

  property p_refresh_hold;
    @(posedge clock) disable iff (reset)
    (refresh_expire || (engine_req.refresh && !engine_ack.refresh)) |=>
      engine_req.refresh;
  endproperty
  a_refresh_hold: assert property (p_refresh_hold)
    else $error("refresh request dropped before acknowledge");

  property p_timeout_flush;
    @(posedge clock) disable iff (reset)
    flush_expire |=> engine_req.flush;
  endproperty
  a_timeout_flush: assert property (p_timeout_flush)
    else $error("timeout did not request a flush");

endmodule

// [sdc_sdram_model.sv]
`timescale 1ns/100ps
module sdc_sdram_model
  import sdc_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            slow,
  input  wire sdc_engine_req_t engine_req,
  output sdc_engine_req_t      engine_ack,
  output logic                 engine_busy
);
  sdc_engine_req_t held;
  int              cnt;
  logic            gap;
  // gap edge lets the acked request drop before we look again
  always @(posedge clock) begin
    engine_ack <= '0;
    gap <= 1'b0;
    if (reset) begin
      engine_busy <= 1'b0;
      held <= '0;
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        engine_ack <= held;
        engine_busy <= 1'b0;
        gap <= 1'b1;
      end
    end else if (!gap && engine_req != '0) begin
      held <= engine_req;
      engine_busy <= 1'b1;
      cnt <= slow ? 20 : 2;
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/100ps
module tb
  import sdc_pkg::*;
;
  logic clock = 1'b0, reset = 1'b1, slow = 1'b0, buffer_write = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, engine_busy, merge_buffer_enable, merge_nb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  sdc_engine_req_t engine_req, engine_ack;
  logic [3:0] rq;
  int errors = 0, n_compared = 0, c;
  int tv[2] = '{10, 4};
  assign rq = engine_req;
  always #10 clock = ~clock;
  sdc_cmd_refresh_merge_buffer_enable u_sdc_cmd_refresh_merge_buffer_enable (.*);
  sdc_sdram_model u_sdc_sdram_model (.*);
  // same bus, built without write buffers; only its enable is watched
  sdc_cmd_refresh_merge_buffer_enable #(
    .HAS_WRITE_BUFFER    (1'b0)
  ) u_sdc_cmd_refresh_merge_buffer_enable_ro (
    .*,
    .s_axi_awready       (),
    .s_axi_wready        (),
    .s_axi_bresp         (),
    .s_axi_bvalid        (),
    .s_axi_arready       (),
    .s_axi_rdata         (),
    .s_axi_rresp         (),
    .s_axi_rvalid        (),
    .engine_req          (),
    .merge_buffer_enable (merge_nb)
  );
  task results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task hang;
    errors++;
    $display("unexpected wait: expected answer seen none");
    results;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_cnt(input string nm, input int e, g);
    n_compared++;
    if (g != e) begin
      errors++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask
  task wr(input logic [31:0] a, dat, output logic [1:0] rs);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang;
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [31:0] a, output logic [31:0] dat,
          output logic [1:0] rs);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang;
    dat = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // cycles to the next low-to-high edge of a request bit, lim+1 if none
  task wait_rise(input int b, lim, output int cnt);
    logic prev;
    prev = rq[b];
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge clock);
      if (prev === 1'b0 && rq[b] === 1'b1) break;
      prev = rq[b];
    end
  endtask
  task pulse;
    @(posedge clock) buffer_write <= 1'b1;
    @(posedge clock) buffer_write <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd(SDC_COMMAND_ADDR, d, r);
    chk("command", 0, d & 32'h7);
    rd(SDC_REFRESH_ADDR, d, r);
    chk("refresh", 32'h20, d);
    rd(SDC_TIMEOUT_ADDR, d, r);
    chk("timeout", 0, d);
    rd(32'hF002_0010, d, r);
    chk("rresp", SDC_RESP_SLVERR, r);
    wr(32'hF002_0000, 32'h4, r);
    chk("bresp", SDC_RESP_SLVERR, r);
    chk("enable", 0, merge_buffer_enable);
    $display("test reset done");
    wait_rise(1, 80, c);
    wait_rise(1, 80, c);
    chk_cnt("refresh gap", 32, c);
    wr(SDC_REFRESH_ADDR, 32'h14, r);
    wait_rise(1, 80, c);
    wait_rise(1, 80, c);
    chk_cnt("refresh gap", 20, c);
    wr(SDC_REFRESH_ADDR, 32'h3E8, r);
    wait_rise(1, 80, c);
    wait_rise(1, 1100, c);
    chk_cnt("refresh gap", 1000, c);
    $display("test refresh done");
    // let the refresh just seen be served, so the engine is idle
    repeat (10) @(posedge clock);
    rd(SDC_COMMAND_ADDR, d, r);
    chk("busy", 0, d & 32'h8);
    slow <= 1'b1;
    for (int k = 1; k < 3; k++) begin
      wr(SDC_COMMAND_ADDR, k, r);
      rd(SDC_COMMAND_ADDR, d, r);
      chk("pending", 32'h8 | k, d);
      chk("request", 1, rq[4-k]);
      for (c = 0; c < 100 && rq[4-k] !== 1'b0; c++) @(posedge clock);
      if (c == 100) hang;
      rd(SDC_COMMAND_ADDR, d, r);
      chk("init", 0, d & 32'h7);
    end
    wr(SDC_COMMAND_ADDR, 32'h3, r);
    rd(SDC_COMMAND_ADDR, d, r);
    chk("reserved", 0, d & 32'h7);
    chk("request", 0, rq[3:2]);
    slow <= 1'b0;
    $display("test init done");
    wr(SDC_COMMAND_ADDR, 32'h4, r);
    rd(SDC_COMMAND_ADDR, d, r);
    chk("command", 32'h4, d & 32'h7);
    chk("enable", 1, merge_buffer_enable);
    chk("fixed enable", 0, merge_nb);
    wr(SDC_COMMAND_ADDR, 32'h0, r);
    // the flush request is already up when the write response is seen
    chk("flush", 1, rq[0]);
    $display("test merge done");
    foreach (tv[i]) begin
      wr(SDC_TIMEOUT_ADDR, tv[i], r);
      wr(SDC_COMMAND_ADDR, 32'h4, r);
      pulse;
      wait_rise(0, 40, c);
      chk_cnt("flush delay", tv[i] + 3, c);
    end
    pulse;
    repeat (2) @(posedge clock);
    pulse;
    wait_rise(0, 40, c);
    chk_cnt("reloaded delay", 7, c);
    wr(SDC_TIMEOUT_ADDR, 32'h0, r);
    pulse;
    wait_rise(0, 60, c);
    chk_cnt("no flush", 61, c);
    $display("test timeout done");
    results;
  end
endmodule
